// >>> hw/exc_trap_map.svh
// Constants of the trap unit.
//
// Functional notes
// RULE1: Maskable acknowledge sets the in-service bit of its level.
// RULE2: Return clears the top in-service bit, not after NMI or exception.
// RULE3: In-service register is read-only and zero after reset.
// RULE4: Software reads in-service bits with interrupts disabled.
// RULE5: Disable flag 0 admits maskable requests; 1 holds them.
// RULE6: Disable, enable, return and status load update the flag.
// RULE7: Maskable acknowledge sets the flag; NMI and exceptions ignore it.
// RULE8: A held request is taken once the flag clears.
// RULE9: Status word resets to 00000020H.
// RULE10: Trap always taken; saves PC, status, cause; sets flags; code drops it when a debug entry comes in the same cycle.
// RULE11: Vectors 00H-0FH go to 00000040H, 10H-1FH to 00000050H.
// RULE12: Return with exception flag reloads PC and status.
// RULE13: Handler restores exception flag 1, NMI flag 0 before return.
// RULE14: Any exception sets the exception-active flag.
// RULE15: Illegal: bits 10:5 ones, bits 26:23 from 7, bit 16 zero.
// RULE16: Illegal opcode saves to debug regs, sets flags, jumps to 00000060H.
// RULE17: Debug trap always taken; same entry as illegal opcode.
// RULE18: Debug return reloads PC and status from debug saves.
// RULE19: Debug saves open only between trap and debug return.
// RULE20: NMI and external pins select rising, falling, both or none.
// RULE21: After reset the NMI pin detects no edge until enabled.
// RULE22: A valid NMI edge releases stop mode, clock halted; code raises STOP_RELEASE only on a synced edge with the clock running.
// RULE23: Select pair: 00 none, 01 rising, 10 falling, 11 both.
// RULE24: Edge selects are 8 bits, bit accessible, zero after reset.
// RULE25: Return clears the lowest set level index first.
`ifndef EXC_TRAP_MAP_SVH
`define EXC_TRAP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADR_IN_SERVICE 8'h00
`define ADR_FALL_SEL 8'h04
`define ADR_RISE_SEL 8'h08
`define ADR_EXC_PC 8'h0C
`define ADR_EXC_STATUS 8'h10
`define ADR_EXC_CAUSE 8'h14
`define ADR_DBG_PC 8'h18
`define ADR_DBG_STATUS 8'h1C
`define ADR_STATUS_WORD 8'h20

// ----------------------------------------------------------------------
// Field positions, reset values and handlers
// ----------------------------------------------------------------------
`define PSW_ID_BIT 5
`define PSW_EP_BIT 6
`define PSW_NP_BIT 7
`define PSW_RESET 32'h00000020
`define SEL_RESET 8'h00
`define NMI_SEL_BIT 2
`define HANDLER_TRAP_LO 32'h00000040
`define HANDLER_TRAP_HI 32'h00000050
`define HANDLER_DEBUG 32'h00000060
`define HANDLER_NMI 32'h00000010
`define HANDLER_MASKABLE 32'h00000080
`define TRAP_CODE_BASE 16'h0040
`define ILG_CODE 16'h0060
`define NMI_CODE 16'h0010
`define MASK_CODE_BASE 16'h0080
`define ILG_OP_VAL 6'h3F
`define ILG_SUB_MIN 4'h7

`endif

// >>> hw/exc_trap_pkg.sv
// Types shared by the trap unit.
package exc_trap_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_mode_t;
endpackage

// >>> hw/cpu_exception_trap_unit.sv
// Exception, trap and interrupt sequencing of the CPU core.
`timescale 1ns/1ps
`default_nettype none
`include "exc_trap_map.svh"

module cpu_exception_trap_unit (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Pipeline instruction events, one-cycle pulses
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] RETURN_PC,
  input wire logic TRAP_INSTR,
  input wire logic [4:0] TRAP_VECTOR,
  input wire logic DEBUG_TRAP_INSTR,
  input wire logic RETURN_FROM_IRQ_INSTR,
  input wire logic DEBUG_RETURN_INSTR,
  input wire logic ENABLE_IRQ_INSTR,
  input wire logic DISABLE_IRQ_INSTR,
  // Maskable request from the peripheral arbiter
  input wire logic IRQ_REQUEST_FLAG,
  input wire logic [2:0] IRQ_LEVEL,
  input wire logic [5:0] IRQ_CODE,
  // Pins
  input wire logic NMI_PIN,
  input wire logic [7:0] EXT_IRQ_PINS,
  input wire logic STOP_MODE,
  // Pipeline redirect
  output logic PC_LOAD,
  output logic [31:0] PC_TARGET,
  output logic IRQ_ACK,
  output logic [31:0] PROGRAM_STATUS_WORD,
  output logic [7:0] EXT_EDGE_DET,
  output logic STOP_RELEASE
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [7:0] in_service_level_ff;
  logic [31:0] psw_ff;
  logic [31:0] exc_return_pc_ff;
  logic [31:0] exc_return_status_ff;
  logic [31:0] exception_cause_ff;
  logic [31:0] dbg_return_pc_ff;
  logic [31:0] dbg_return_status_ff;
  logic dbg_window_ff;
  logic [7:0] fall_edge_select_ff;
  logic [7:0] rise_edge_select_ff;
  logic [7:0] ext_meta_ff;
  logic [7:0] ext_sync_ff;
  logic [7:0] ext_prev_ff;
  logic nmi_meta_ff;
  logic nmi_sync_ff;
  logic nmi_prev_ff;
  logic nmi_pending_ff;
  logic pc_load_ff;
  logic [31:0] pc_target_ff;
  logic irq_ack_ff;
  logic [7:0] ext_edge_ff;
  logic stop_release_ff;
  logic [31:0] rdata_ff;

  logic mask_disable_flag;
  logic exception_active_flag;
  logic nonmaskable_active_flag;
  logic illegal_opcode_trap;
  logic debug_entry;
  logic irq_accept;
  logic nmi_accept;
  logic ret_exc;
  logic nmi_edge;
  logic [7:0] ext_edge;
  logic [7:0] isr_clear;
  logic [7:0] nxt_isr;
  logic [31:0] nxt_psw;

  assign mask_disable_flag = psw_ff[`PSW_ID_BIT];
  assign exception_active_flag = psw_ff[`PSW_EP_BIT];
  assign nonmaskable_active_flag = psw_ff[`PSW_NP_BIT];

  // --------------------------------------------------------------------
  // Decode and arbitration
  // --------------------------------------------------------------------
  // Only an issued instruction can be illegal.
  assign illegal_opcode_trap = INSTR_VALID &&
    (INSTR_WORD[10:5] == `ILG_OP_VAL) &&
    (INSTR_WORD[26:23] >= `ILG_SUB_MIN) && !INSTR_WORD[16]; // RULE15
  assign debug_entry = illegal_opcode_trap || DEBUG_TRAP_INSTR; // RULE17
  // Trap, debug and return events outrank both requests, so none is lost;
  // a pending request waits a cycle.
  assign nmi_accept = nmi_pending_ff && !debug_entry && !TRAP_INSTR &&
    !RETURN_FROM_IRQ_INSTR && !DEBUG_RETURN_INSTR; // RULE7
  assign irq_accept = IRQ_REQUEST_FLAG && !mask_disable_flag &&
    !nmi_accept && !nmi_pending_ff && !debug_entry && !TRAP_INSTR &&
    !RETURN_FROM_IRQ_INSTR && !DEBUG_RETURN_INSTR &&
    !ENABLE_IRQ_INSTR && !DISABLE_IRQ_INSTR; // RULE5 RULE8
  assign ret_exc = RETURN_FROM_IRQ_INSTR && exception_active_flag;

  // Lowest index wins; the one-hot of the lowest set bit is x & -x.
  assign isr_clear = in_service_level_ff &
    (~in_service_level_ff + 8'h01); // RULE25

  // --------------------------------------------------------------------
  // In-service register next value
  // --------------------------------------------------------------------
  always_comb begin
    nxt_isr = in_service_level_ff;
    if (irq_accept) begin
      nxt_isr = in_service_level_ff | (8'h01 << IRQ_LEVEL); // RULE1
    end else if (RETURN_FROM_IRQ_INSTR && !exception_active_flag &&
                 !nonmaskable_active_flag) begin
      nxt_isr = in_service_level_ff & ~isr_clear; // RULE2
    end
  end

  // --------------------------------------------------------------------
  // Status word next value
  // --------------------------------------------------------------------
  always_comb begin
    nxt_psw = psw_ff;
    if (debug_entry) begin
      nxt_psw[`PSW_NP_BIT] = 1'b1; // RULE16
      nxt_psw[`PSW_EP_BIT] = 1'b1; // RULE14
      nxt_psw[`PSW_ID_BIT] = 1'b1;
    end else if (TRAP_INSTR) begin
      nxt_psw[`PSW_EP_BIT] = 1'b1; // RULE10 RULE14
      nxt_psw[`PSW_ID_BIT] = 1'b1;
    end else if (DEBUG_RETURN_INSTR) begin
      nxt_psw = dbg_return_status_ff; // RULE18
    end else if (RETURN_FROM_IRQ_INSTR) begin
      // Plain return leaves PC and status to the pipeline;
      // only the exception path reloads here.
      if (ret_exc) begin
        nxt_psw = exc_return_status_ff; // RULE12 RULE6
      end
    end else if (nmi_accept) begin
      nxt_psw[`PSW_NP_BIT] = 1'b1;
      nxt_psw[`PSW_ID_BIT] = 1'b1;
    end else if (irq_accept) begin
      nxt_psw[`PSW_ID_BIT] = 1'b1; // RULE7
    end else if (DISABLE_IRQ_INSTR) begin
      nxt_psw[`PSW_ID_BIT] = 1'b1; // RULE6
    end else if (ENABLE_IRQ_INSTR) begin
      nxt_psw[`PSW_ID_BIT] = 1'b0; // RULE6
    end else if (REG_WR && REG_ADDR == `ADR_STATUS_WORD) begin
      nxt_psw = REG_WDATA; // RULE6
    end
  end

  // Status word and in-service levels.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      psw_ff <= `PSW_RESET; // RULE9
      in_service_level_ff <= 8'h00; // RULE3
    end else begin
      psw_ff <= nxt_psw;
      in_service_level_ff <= nxt_isr;
    end
  end

  // --------------------------------------------------------------------
  // Exception save registers and cause
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      exc_return_pc_ff <= 32'h00000000;
      exc_return_status_ff <= 32'h00000000;
      exception_cause_ff <= 32'h00000000;
    end else if (TRAP_INSTR && !debug_entry) begin
      exc_return_pc_ff <= RETURN_PC; // RULE10
      exc_return_status_ff <= psw_ff;
      exception_cause_ff[15:0] <= `TRAP_CODE_BASE | {11'h000, TRAP_VECTOR};
    end else if (nmi_accept) begin
      exception_cause_ff[31:16] <= `NMI_CODE;
    end else if (irq_accept) begin
      exception_cause_ff[15:0] <= `MASK_CODE_BASE | {10'h000, IRQ_CODE};
    end else if (illegal_opcode_trap) begin
      exception_cause_ff[31:16] <= `ILG_CODE;
    end else if (REG_WR) begin
      if (REG_ADDR == `ADR_EXC_PC) begin
        exc_return_pc_ff <= REG_WDATA;
      end else if (REG_ADDR == `ADR_EXC_STATUS) begin
        exc_return_status_ff <= REG_WDATA;
      end
    end
  end

  // --------------------------------------------------------------------
  // Debug save registers, open only inside a debug trap
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      dbg_return_pc_ff <= 32'h00000000;
      dbg_return_status_ff <= 32'h00000000;
      dbg_window_ff <= 1'b0;
    end else if (debug_entry) begin
      dbg_return_pc_ff <= RETURN_PC; // RULE16 RULE17
      dbg_return_status_ff <= psw_ff;
      dbg_window_ff <= 1'b1; // RULE19
    end else if (DEBUG_RETURN_INSTR) begin
      dbg_window_ff <= 1'b0; // RULE19
    end else if (REG_WR && dbg_window_ff) begin
      if (REG_ADDR == `ADR_DBG_PC) begin
        dbg_return_pc_ff <= REG_WDATA; // RULE19
      end else if (REG_ADDR == `ADR_DBG_STATUS) begin
        dbg_return_status_ff <= REG_WDATA;
      end
    end
  end

  // --------------------------------------------------------------------
  // Edge-select registers
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      fall_edge_select_ff <= `SEL_RESET; // RULE24 RULE21
      rise_edge_select_ff <= `SEL_RESET;
    end else if (REG_WR && REG_ADDR == `ADR_FALL_SEL) begin
      fall_edge_select_ff <= REG_WDATA[7:0];
    end else if (REG_WR && REG_ADDR == `ADR_RISE_SEL) begin
      rise_edge_select_ff <= REG_WDATA[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ext_meta_ff <= 8'h00;
      ext_sync_ff <= 8'h00;
      ext_prev_ff <= 8'h00;
      nmi_meta_ff <= 1'b0;
      nmi_sync_ff <= 1'b0;
      nmi_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= EXT_IRQ_PINS;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
      nmi_meta_ff <= NMI_PIN;
      nmi_sync_ff <= nmi_meta_ff;
      nmi_prev_ff <= nmi_sync_ff;
    end
  end

  // Each pin decodes its select pair into a mode.
  always_comb begin
    exc_trap_pkg::edge_mode_t mode;
    mode = exc_trap_pkg::EDGE_NONE;
    for (int i = 0; i < 8; i++) begin
      mode = exc_trap_pkg::edge_mode_t'({fall_edge_select_ff[i],
                                         rise_edge_select_ff[i]}); // RULE23
      case (mode)
        exc_trap_pkg::EDGE_RISE: ext_edge[i] = ext_sync_ff[i] &&
                                               !ext_prev_ff[i];
        exc_trap_pkg::EDGE_FALL: ext_edge[i] = !ext_sync_ff[i] &&
                                               ext_prev_ff[i];
        exc_trap_pkg::EDGE_BOTH: ext_edge[i] = ext_sync_ff[i] ^
                                               ext_prev_ff[i];
        default: ext_edge[i] = 1'b0; // RULE20
      endcase
    end
  end

  // The NMI pin shares select pair 2 with external pin 2.
  always_comb begin
    exc_trap_pkg::edge_mode_t nmode;
    nmode = exc_trap_pkg::edge_mode_t'(
      {fall_edge_select_ff[`NMI_SEL_BIT], rise_edge_select_ff[`NMI_SEL_BIT]});
    case (nmode)
      exc_trap_pkg::EDGE_RISE: nmi_edge = nmi_sync_ff && !nmi_prev_ff;
      exc_trap_pkg::EDGE_FALL: nmi_edge = !nmi_sync_ff && nmi_prev_ff;
      exc_trap_pkg::EDGE_BOTH: nmi_edge = nmi_sync_ff ^ nmi_prev_ff;
      default: nmi_edge = 1'b0; // RULE21
    endcase
  end

  // NMI latch: a new edge in the accepting cycle wins over the clear.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      nmi_pending_ff <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pending_ff <= 1'b1;
    end else if (nmi_accept) begin
      nmi_pending_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Pipeline outputs
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pc_load_ff <= 1'b0;
      pc_target_ff <= 32'h00000000;
      irq_ack_ff <= 1'b0;
      ext_edge_ff <= 8'h00;
    end else begin
      pc_load_ff <= debug_entry || TRAP_INSTR || DEBUG_RETURN_INSTR ||
                    ret_exc || nmi_accept || irq_accept;
      irq_ack_ff <= irq_accept;
      ext_edge_ff <= ext_edge;
      if (debug_entry) begin
        pc_target_ff <= `HANDLER_DEBUG; // RULE16 RULE17
      end else if (TRAP_INSTR) begin
        pc_target_ff <= TRAP_VECTOR[4] ? `HANDLER_TRAP_HI
                                       : `HANDLER_TRAP_LO; // RULE11
      end else if (DEBUG_RETURN_INSTR) begin
        pc_target_ff <= dbg_return_pc_ff; // RULE18
      end else if (ret_exc) begin
        pc_target_ff <= exc_return_pc_ff; // RULE12
      end else if (nmi_accept) begin
        pc_target_ff <= `HANDLER_NMI;
      end else if (irq_accept) begin
        pc_target_ff <= `HANDLER_MASKABLE | {24'h000000, IRQ_CODE, 2'b00};
      end
    end
  end

  // Wake pulse from the synced edge; it needs a running clock,
  // so the stop controller watches the pin itself
  // while the clock is halted.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      stop_release_ff <= 1'b0;
    end else begin
      stop_release_ff <= STOP_MODE && nmi_edge; // RULE22
    end
  end

  // --------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_ff <= 32'h00000000;
    end else if (REG_RD) begin
      if (REG_ADDR == `ADR_IN_SERVICE) begin
        rdata_ff <= {24'h000000, in_service_level_ff}; // RULE3
      end else if (REG_ADDR == `ADR_FALL_SEL) begin
        rdata_ff <= {24'h000000, fall_edge_select_ff};
      end else if (REG_ADDR == `ADR_RISE_SEL) begin
        rdata_ff <= {24'h000000, rise_edge_select_ff};
      end else if (REG_ADDR == `ADR_EXC_PC) begin
        rdata_ff <= exc_return_pc_ff;
      end else if (REG_ADDR == `ADR_EXC_STATUS) begin
        rdata_ff <= exc_return_status_ff;
      end else if (REG_ADDR == `ADR_EXC_CAUSE) begin
        rdata_ff <= exception_cause_ff;
      end else if (REG_ADDR == `ADR_DBG_PC && dbg_window_ff) begin
        rdata_ff <= dbg_return_pc_ff; // RULE19
      end else if (REG_ADDR == `ADR_DBG_STATUS && dbg_window_ff) begin
        rdata_ff <= dbg_return_status_ff;
      end else if (REG_ADDR == `ADR_STATUS_WORD) begin
        rdata_ff <= psw_ff;
      end else begin
        rdata_ff <= 32'h00000000;
      end
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign PC_LOAD = pc_load_ff;
  assign PC_TARGET = pc_target_ff;
  assign IRQ_ACK = irq_ack_ff;
  assign PROGRAM_STATUS_WORD = psw_ff;
  assign EXT_EDGE_DET = ext_edge_ff;
  assign STOP_RELEASE = stop_release_ff;

endmodule
`default_nettype wire

// >>> testbench/exc_trap_unit_properties.sv
// Port-level checks of the trap unit.
`timescale 1ns/1ps
`default_nettype none
`include "exc_trap_map.svh"

module exc_trap_chk (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Register port and pipeline events
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] RETURN_PC,
  input wire logic TRAP_INSTR,
  input wire logic [4:0] TRAP_VECTOR,
  input wire logic DEBUG_TRAP_INSTR,
  input wire logic DEBUG_RETURN_INSTR,
  input wire logic DISABLE_IRQ_INSTR,
  input wire logic IRQ_REQUEST_FLAG,
  input wire logic [5:0] IRQ_CODE,
  // Redirect and status
  input wire logic PC_LOAD,
  input wire logic [31:0] PC_TARGET,
  input wire logic IRQ_ACK,
  input wire logic [31:0] PROGRAM_STATUS_WORD
);
  logic dbg_entry;
  logic vec_hi_ff, nmi_armed_ff;
  logic [5:0] code_ff;
  logic [31:0] dbg_pc_ff;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  // An illegal opcode or a debug trap opens the debug path.
  assign dbg_entry = DEBUG_TRAP_INSTR || (INSTR_VALID && !INSTR_WORD[16] &&
    INSTR_WORD[10:5] == `ILG_OP_VAL && INSTR_WORD[26:23] >= `ILG_SUB_MIN);

  // Inputs the next redirect is built from.
  always_ff @(posedge CORE_CLK) begin
    vec_hi_ff <= TRAP_VECTOR[4];
    code_ff <= IRQ_CODE;
    if (dbg_entry) begin
      dbg_pc_ff <= RETURN_PC;
    end
  end

  // A write that sets an NMI select bit ends this check.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      nmi_armed_ff <= 1'h0;
    end else if (REG_WR && REG_WDATA[`NMI_SEL_BIT] &&
      (REG_ADDR == `ADR_FALL_SEL || REG_ADDR == `ADR_RISE_SEL)) begin
      nmi_armed_ff <= 1'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_psw_reset;
    $fell(SYS_RST) |-> PROGRAM_STATUS_WORD == `PSW_RESET;
  endproperty
  a_psw_reset: assert property (p_psw_reset)
    else $error("status word wrong after reset");
  property p_ack;
    IRQ_ACK |-> PC_LOAD && PROGRAM_STATUS_WORD[`PSW_ID_BIT] &&
      PC_TARGET == (`HANDLER_MASKABLE | {24'h000000, code_ff, 2'h0});
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge without disable or handler");
  property p_held;
    (!IRQ_REQUEST_FLAG || PROGRAM_STATUS_WORD[`PSW_ID_BIT]) |=> !IRQ_ACK;
  endproperty
  a_held: assert property (p_held)
    else $error("request acknowledged while held");
  property p_trap;
    TRAP_INSTR && !dbg_entry |=> PC_LOAD &&
      PROGRAM_STATUS_WORD[6:5] == 2'h3 &&
      PC_TARGET == (vec_hi_ff ? `HANDLER_TRAP_HI : `HANDLER_TRAP_LO);
  endproperty
  a_trap: assert property (p_trap)
    else $error("software trap entry wrong");
  property p_dbg;
    dbg_entry |=> PC_LOAD && PC_TARGET == `HANDLER_DEBUG &&
      PROGRAM_STATUS_WORD[7:5] == 3'h7;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug entry wrong");
  property p_dbg_ret;
    DEBUG_RETURN_INSTR && !dbg_entry && !TRAP_INSTR |=>
      PC_LOAD && PC_TARGET == dbg_pc_ff;
  endproperty
  a_dbg_ret: assert property (p_dbg_ret)
    else $error("debug return target wrong");
  property p_di;
    DISABLE_IRQ_INSTR |=> PROGRAM_STATUS_WORD[`PSW_ID_BIT];
  endproperty
  a_di: assert property (p_di)
    else $error("disable instruction left flag clear");
  property p_nmi_off;
    !nmi_armed_ff |-> !(PC_LOAD && PC_TARGET == `HANDLER_NMI);
  endproperty
  a_nmi_off: assert property (p_nmi_off)
    else $error("NMI taken before an edge was enabled");
  c_ack: cover property (IRQ_ACK);
  c_dbg: cover property (dbg_entry ##1 PC_LOAD);
  c_trap: cover property (TRAP_INSTR ##1 PC_LOAD);
endmodule

bind cpu_exception_trap_unit exc_trap_chk chk (.*);
`default_nettype wire

// >>> testbench/irq_source_model.sv
// Model of the peripheral request arbiter.
`timescale 1ns/1ps
`default_nettype none

module irq_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic post,
  input wire logic [2:0] post_level,
  input wire logic [5:0] post_code,
  // Request side
  input wire logic ack,
  output logic req,
  output logic [2:0] level,
  output logic [5:0] code
);
  // Requests stay up until acked; idle lines toggle so stale values fail.
  always_ff @(posedge clk) begin
    if (rst) begin
      req <= 1'h0;
      level <= 3'h0;
      code <= 6'h00;
    end else if (post) begin
      req <= 1'h1;
      level <= post_level;
      code <= post_code;
    end else if (ack || !req) begin
      req <= 1'h0;
      level <= ~level;
      code <= ~code;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/cpu_exception_trap_unit_test.sv
// Self-checking bench of the trap unit.
`timescale 1ns/1ps
`default_nettype none
`include "exc_trap_map.svh"

module cpu_exception_trap_unit_test;
  localparam logic [31:0] all = 32'hFFFFFFFF;
  localparam logic [6:0] ev_trap = 7'h01, ev_dbt = 7'h02, ev_ret = 7'h04;
  localparam logic [6:0] ev_dbr = 7'h08, ev_ei = 7'h10, ev_di = 7'h20;
  localparam logic [6:0] ev_ilg = 7'h40;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, rd_wait = 1'h0;
  logic nmi = 1'h0, stop = 1'h0, post = 1'h0, req, ack, pc_load, wake;
  logic [6:0] ev = 7'h00;
  logic [7:0] addr = 8'h00, pins = 8'h00, edges;
  logic [31:0] wdata = 32'h0, rpc = 32'h0, iword = 32'h0;
  logic [31:0] rdata, target, program_status_word, pc, w;
  logic [4:0] vec = 5'h00;
  logic [4:0] vtab[5];
  logic [2:0] plevel = 3'h0, lvl;
  logic [5:0] pcode = 6'h00, code, c;
  logic [63:0] rd_q[$], pc_q[$], n;
  int bad_count = 0, cmp_count = 0, edge_cnt = 0, wake_cnt = 0, e0;

  cpu_exception_trap_unit uut (.CORE_CLK(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .INSTR_VALID(ev[6]), .INSTR_WORD(iword),
    .RETURN_PC(rpc), .TRAP_INSTR(ev[0]), .TRAP_VECTOR(vec),
    .DEBUG_TRAP_INSTR(ev[1]), .RETURN_FROM_IRQ_INSTR(ev[2]),
    .DEBUG_RETURN_INSTR(ev[3]), .ENABLE_IRQ_INSTR(ev[4]),
    .DISABLE_IRQ_INSTR(ev[5]), .IRQ_REQUEST_FLAG(req), .IRQ_LEVEL(lvl),
    .IRQ_CODE(code), .NMI_PIN(nmi), .EXT_IRQ_PINS(pins), .STOP_MODE(stop),
    .PC_LOAD(pc_load), .PC_TARGET(target), .IRQ_ACK(ack),
    .PROGRAM_STATUS_WORD(program_status_word), .EXT_EDGE_DET(edges), .STOP_RELEASE(wake));
  irq_source src (.clk(clk), .rst(rst), .post(post), .post_level(plevel),
    .post_code(pcode), .ack(ack), .req(req), .level(lvl), .code(code));

  // Free-running core clock at 25 MHz.
  always #20 clk = ~clk;

  // ----------------------------------------------------------------------
  // Checking and driving tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One bus cycle; a read queues its masked expectation.
  task automatic bus(input logic wr_n, input logic [7:0] a,
                     input logic [31:0] d, m);
    @(posedge clk);
    if (!wr_n) rd_q.push_back({m, d});
    wr <= wr_n;
    rd <= !wr_n;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic issue(input logic [6:0] e, input logic [31:0] p);
    @(posedge clk);
    ev <= e;
    rpc <= p;
    @(posedge clk);
    ev <= 7'h00;
    tick(4);
  endtask
  task automatic raise(input logic [2:0] l, input logic [5:0] k);
    @(posedge clk);
    post <= 1'h1;
    plevel <= l;
    pcode <= k;
    @(posedge clk);
    post <= 1'h0;
    tick(4);
  endtask

  // An unexpected redirect meets a zero target and fails.
  always @(posedge clk) begin
    if (rd_wait) begin
      n = rd_q.pop_front();
      check("read data", n[31:0] & n[63:32], rdata & n[63:32]);
    end
    rd_wait = rd;
    if (pc_load === 1'h1) begin
      n = pc_q.size() > 0 ? pc_q.pop_front() : 64'h0;
      check("redirect target", n[63:32], target);
      check("status word", n[31:0], program_status_word);
    end
    if (edges[0] === 1'h1) edge_cnt++;
    if (wake === 1'h1) wake_cnt++;
  end

  // Hang guard, well past the test length.
  initial begin
    tick(20000);
    bad_count++;
    complete_run;
  end

  // Main sequence.
  initial begin
    pc = $urandom(32'h413F);
    tick(6);
    rst <= 1'h0;
    nmi <= 1'h1;
    bus(1'h0, `ADR_STATUS_WORD, `PSW_RESET, all);
    bus(1'h0, `ADR_IN_SERVICE, 32'h0, all);
    bus(1'h1, `ADR_IN_SERVICE, all, 32'h0);
    bus(1'h0, `ADR_IN_SERVICE, 32'h0, all);
    bus(1'h0, `ADR_FALL_SEL, 32'h0, all);
    bus(1'h0, `ADR_RISE_SEL, 32'h0, all);
    bus(1'h0, 8'hF0, 32'h0, all);
    nmi <= 1'h0;
    $display("reset test done");
    c = 6'($urandom);
    raise(3'h5, c);
    tick(8);
    bus(1'h0, `ADR_IN_SERVICE, 32'h0, all);
    pc_q.push_back({`HANDLER_MASKABLE | {24'h0, c, 2'h0}, `PSW_RESET});
    issue(ev_ei, 32'h0);
    bus(1'h0, `ADR_IN_SERVICE, 32'h20, all);
    issue(ev_ei, 32'h0);
    c = 6'($urandom);
    pc_q.push_back({`HANDLER_MASKABLE | {24'h0, c, 2'h0}, `PSW_RESET});
    raise(3'h2, c);
    bus(1'h0, `ADR_IN_SERVICE, 32'h24, all);
    issue(ev_ret, 32'h0);
    bus(1'h0, `ADR_IN_SERVICE, 32'h20, all);
    issue(ev_ret, 32'h0);
    bus(1'h0, `ADR_IN_SERVICE, 32'h0, all);
    $display("maskable test done");
    vtab = '{5'h00, 5'h0F, 5'h10, 5'h1F, 5'h00};
    vtab[4] = 5'($urandom);
    foreach (vtab[i]) begin
      pc = $urandom;
      vec <= vtab[i];
      pc_q.push_back({vtab[i][4] ? `HANDLER_TRAP_HI : `HANDLER_TRAP_LO,
        32'h60});
      issue(ev_trap, pc);
      bus(1'h0, `ADR_EXC_PC, pc, all);
      bus(1'h0, `ADR_EXC_STATUS, `PSW_RESET, all);
      bus(1'h0, `ADR_EXC_CAUSE, {16'h0, `TRAP_CODE_BASE | vtab[i]},
        32'h0000FFFF);
      pc_q.push_back({pc, `PSW_RESET});
      issue(ev_ret, 32'h0);
      bus(1'h0, `ADR_IN_SERVICE, 32'h0, all);
    end
    $display("software trap test done");
    for (int k = 0; k < 2; k++) begin
      pc = $urandom;
      w = $urandom;
      w[10:5] = `ILG_OP_VAL;
      w[26:23] = 4'hF - 4'($urandom % 9);
      w[16] = 1'h0;
      iword <= w;
      pc_q.push_back({`HANDLER_DEBUG, 32'hE0});
      issue(k ? ev_dbt : ev_ilg, pc);
      bus(1'h0, `ADR_DBG_PC, pc, all);
      bus(1'h0, `ADR_DBG_STATUS, `PSW_RESET, all);
      pc_q.push_back({pc, `PSW_RESET});
      issue(ev_dbr, 32'h0);
      bus(1'h0, `ADR_DBG_PC, 32'h0, all);
    end
    w[26:23] = 4'h6;
    iword <= w;
    issue(ev_ilg, 32'h0);
    w[26:23] = 4'h7;
    w[16] = 1'h1;
    iword <= w;
    issue(ev_ilg, 32'h0);
    bus(1'h1, `ADR_STATUS_WORD, 32'h0, 32'h0);
    bus(1'h0, `ADR_STATUS_WORD, 32'h0, all);
    issue(ev_di, 32'h0);
    bus(1'h0, `ADR_STATUS_WORD, `PSW_RESET, all);
    $display("debug trap test done");
    for (int m = 0; m < 4; m++) begin
      bus(1'h1, `ADR_FALL_SEL, 32'(m / 2), 32'h0);
      bus(1'h1, `ADR_RISE_SEL, 32'(m % 2), 32'h0);
      e0 = edge_cnt;
      pins[0] <= 1'h1;
      tick(8);
      pins[0] <= 1'h0;
      tick(8);
      check("edge count", 32'(m / 2 + m % 2), 32'(edge_cnt - e0));
    end
    bus(1'h1, `ADR_FALL_SEL, 32'h0, 32'h0);
    bus(1'h1, `ADR_RISE_SEL, 32'h4, 32'h0);
    stop <= 1'h1;
    pc_q.push_back({`HANDLER_NMI, 32'hA0});
    nmi <= 1'h1;
    tick(12);
    check("wake count", 32'h1, 32'(wake_cnt));
    check("redirects left", 32'h0, 32'(pc_q.size()));
    $display("pin edge test done");
    complete_run;
  end
endmodule
`default_nettype wire
